// ==== bfpg_ctrl.sv ====
// Top of the step-down converter fault, start-up and power-good supervisor
`timescale 1ns/1ps

// What this block does
// - Overcurrent during a cycle turns high side off and low side on at once.
// - After a current-limit end, high side returns only at the next cycle start.
// - Build option chooses hiccup recovery or latch-off for repeated overcurrent.
// - Hiccup: after 32 back-to-back limit cycles hold high side off 9.6 ms.
// - After the hiccup pause, restart on its own through soft start.
// - Hiccup bursts and pauses repeat as long as the overload stays.
// - Latch option: 32 limit cycles stop switching until enable or power cycles.
// - Latch option: overvoltage when upper comparator holds longer than 35 us.
// - Confirmed overvoltage drops power good and latches both transistors off.
// - Input undervoltage keeps the power stage idle.
// - Over-temperature shuts down; operation resumes once the flag clears.
// - Enable high starts; enable low stops all and sinks the output; never float it.
// - Output near input: high side constantly on, low side off.
// - Power good released at nominal output, low when disabled, undervolt or hot.
// - Power good window: good from 0.48 V, bad at 0.55 V, back below 0.525 V.
// - Each window-driven power-good change waits until its condition held 40 us; forced low is immediate.
// - First power-good release waits 125 us after soft start ends.
// - After enable, load defaults within 120 us, then start soft start.
// - Mode input high forces fixed-frequency operation, never power save.
module bfpg_ctrl #(
  parameter logic LATCH_OFF_VARIANT = 1'b0,
  parameter bfpg_pkg::bfpg_cnt_t LOAD_CYC = bfpg_pkg::LOAD_CYCLES,
  parameter bfpg_pkg::bfpg_cnt_t HICCUP_CYC = bfpg_pkg::HICCUP_CYCLES,
  parameter bfpg_pkg::bfpg_cnt_t OVERVOLT_CYC = bfpg_pkg::OVERVOLT_CYCLES,
  parameter bfpg_pkg::bfpg_cnt_t GOOD_DELAY_CYC = bfpg_pkg::PWR_GOOD_DELAY_CYCLES,
  parameter bfpg_pkg::bfpg_cnt_t GOOD_BLANK_CYC = bfpg_pkg::PWR_GOOD_BLANK_CYCLES
)
(
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire bfpg_pkg::bfpg_axi_req_t S_AXI_REQ_I,
  output bfpg_pkg::bfpg_axi_rsp_t S_AXI_RSP_O,
  input wire logic ENABLE_I,
  input wire logic INPUT_UNDERVOLTAGE_I,
  input wire logic THERMAL_TRIP_I,
  input wire logic HS_OVERCURRENT_I,
  input wire logic FEEDBACK_LOW_OK_I,
  input wire logic FEEDBACK_OVER_I,
  input wire logic NEAR_VIN_I,
  input wire logic MODE_FORCED_PWM_I,
  input wire logic ZERO_CROSS_I,
  input wire logic PWM_ON_I,
  input wire logic RAMP_DONE_I,
  input wire logic CYCLE_CLK_I,
  input wire logic PWR_GOOD_I,
  output logic HS_ON_O,
  output logic LS_ON_O,
  output logic DISCHARGE_O,
  output logic RAMP_START_O,
  output logic POWER_SAVE_O,
  output logic PWR_GOOD_O,
  output logic PWR_GOOD_OE_O
);
  import bfpg_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  bfpg_pins_t raw, s1_q, s2_q, s3_q, pin_q, pin_d;
  logic cyc_prev_q;
  logic good_pin_s1_q, good_pin_s2_q;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign raw = '{enable: ENABLE_I, undervolt: INPUT_UNDERVOLTAGE_I, thermal: THERMAL_TRIP_I,
                 overcurrent: HS_OVERCURRENT_I, feedback_ok_low: FEEDBACK_LOW_OK_I,
                 feedback_over: FEEDBACK_OVER_I, near_vin: NEAR_VIN_I,
                 forced_pwm: MODE_FORCED_PWM_I, zero_cross: ZERO_CROSS_I,
                 pwm_on: PWM_ON_I, ramp_done: RAMP_DONE_I, cycle_clk: CYCLE_CLK_I};

  // A bit moves only once the second and third stages agree
  always_comb
  begin
    pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
      cyc_prev_q <= 1'b0;
      good_pin_s1_q <= 1'b0;
      good_pin_s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
      cyc_prev_q <= pin_q.cycle_clk;
      good_pin_s1_q <= PWR_GOOD_I;
      good_pin_s2_q <= good_pin_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic wr_en, wr_err, rd_en, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  bfpg_axil_slave u_axil
  (
    .clk_i(SYS_CLK_I),
    .rst_ni(rst_n),
    .axi_req_i(S_AXI_REQ_I),
    .axi_rsp_o(S_AXI_RSP_O),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_err),
    .rd_en_o(rd_en),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // ----------------------------------------------------------------------
  // Sequencer, current limit and fault handling
  // ----------------------------------------------------------------------
  bfpg_state_t st_q, st_d;
  bfpg_cnt_t tmr_q, tmr_d, ov_cnt_q, ov_cnt_d;
  logic [5:0] occ_q, occ_d;
  logic oc_term_q, oc_term_d, host_en_q, host_en_d;
  logic [3:0] ev_q, ev_d, ev_set;
  logic hs_q, hs_d, ls_q, ls_d, dis_q, dis_d, ramp_q, ramp_d, psave_q, psave_d;
  logic good_q, good_int;
  logic en_ok, fault, switching, sw_next, cycle_start, trip, ov_hit, window_ok;

  always_comb
  begin
    en_ok = pin_q.enable & host_en_q;
    fault = pin_q.undervolt | pin_q.thermal;
    switching = (st_q == ST_RUN || st_q == ST_SOFT) && en_ok && !fault;
    cycle_start = pin_q.cycle_clk & !cyc_prev_q;
    trip = switching & cycle_start & oc_term_q & (occ_q == OC_TRIP_COUNT - OC_COUNT_ONE);
    ov_hit = LATCH_OFF_VARIANT & switching & pin_q.feedback_over
           & (ov_cnt_q == OVERVOLT_CYC);
    st_d = st_q;
    unique case (st_q)
      ST_OFF:
        if (en_ok && !fault)
          st_d = ST_LOAD;
      ST_LOAD:
        if (tmr_q == LOAD_CYC - CNT_ONE)
          st_d = ST_SOFT;
      ST_SOFT:
        if (pin_q.ramp_done)
          st_d = ST_RUN;
      ST_RUN:
        st_d = ST_RUN;
      ST_HICCUP:
        if (tmr_q == HICCUP_CYC - CNT_ONE)
          st_d = ST_SOFT;
      ST_LATCHED:
        st_d = ST_LATCHED;
    endcase
    if (trip)
      st_d = LATCH_OFF_VARIANT ? ST_LATCHED : ST_HICCUP;
    if (ov_hit)
      st_d = ST_LATCHED;
    // A latched converter ignores clearing faults; only enable releases it
    if (fault && st_q != ST_LATCHED)
      st_d = ST_OFF;
    if (!en_ok)
      st_d = ST_OFF;
    tmr_d = (st_d != st_q) ? CNT_ZERO : tmr_q + CNT_ONE;
    ov_cnt_d = (switching && pin_q.feedback_over && ov_cnt_q != OVERVOLT_CYC)
             ? ov_cnt_q + CNT_ONE : (switching && pin_q.feedback_over ? ov_cnt_q : CNT_ZERO);
    oc_term_d = pin_q.overcurrent | (oc_term_q & !cycle_start);
    occ_d = occ_q;
    if (!switching)
      occ_d = 6'h00;
    else if (cycle_start)
      occ_d = oc_term_q ? occ_q + OC_COUNT_ONE : 6'h00;
    sw_next = (st_d == ST_RUN || st_d == ST_SOFT);
    hs_d = sw_next & !oc_term_d & (pin_q.near_vin | pin_q.pwm_on);
    ls_d = sw_next & !hs_d
         & (oc_term_d | (!pin_q.near_vin & (pin_q.forced_pwm | !pin_q.zero_cross)));
    psave_d = sw_next & !hs_d & !oc_term_d & !pin_q.near_vin
            & !pin_q.forced_pwm & pin_q.zero_cross;
    dis_d = !en_ok;
    ramp_d = (st_d == ST_SOFT);
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_comb
  begin
    ev_set = 4'h0;
    ev_set[EV_OC_CYCLE] = switching & pin_q.overcurrent;
    ev_set[EV_HICCUP] = trip & !LATCH_OFF_VARIANT;
    ev_set[EV_OC_LATCH] = trip & LATCH_OFF_VARIANT;
    ev_set[EV_OVERVOLT] = ov_hit;
    host_en_d = host_en_q;
    ev_d = ev_q;
    wr_err = 1'b0;
    if (wr_en)
    begin
      if (wr_addr == REG_CTRL_OFS && wr_strb[0])
        host_en_d = wr_data[0];
      else if (wr_addr == REG_EVENT_OFS && wr_strb[0])
        ev_d = ev_q & ~wr_data[3:0];
      else if (wr_addr != REG_STATUS_OFS && wr_addr != REG_CTRL_OFS
               && wr_addr != REG_EVENT_OFS)
        wr_err = 1'b1;
    end
    // New events win over a clear in the same cycle
    ev_d = ev_d | ev_set;
    rd_err = 1'b0;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      REG_CTRL_OFS:
        rd_data = {31'h0000_0000, host_en_q};
      REG_STATUS_OFS:
        rd_data = {14'h0000, good_pin_s2_q, LATCH_OFF_VARIANT, ls_q, hs_q, good_q,
                   oc_term_q, occ_q, st_q};
      REG_EVENT_OFS:
        rd_data = {28'h000_0000, ev_q};
      default:
        rd_err = rd_en;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_OFF;
      tmr_q <= CNT_ZERO;
      ov_cnt_q <= CNT_ZERO;
      occ_q <= 6'h00;
      oc_term_q <= 1'b0;
      host_en_q <= CTRL_RESET[0];
      ev_q <= 4'h0;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      dis_q <= 1'b1;
      ramp_q <= 1'b0;
      psave_q <= 1'b0;
      good_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ov_cnt_q <= ov_cnt_d;
      occ_q <= occ_d;
      oc_term_q <= oc_term_d;
      host_en_q <= host_en_d;
      ev_q <= ev_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
      dis_q <= dis_d;
      ramp_q <= ramp_d;
      psave_q <= psave_d;
      good_q <= good_int;
    end
  end

  // ----------------------------------------------------------------------
  // Power good
  // ----------------------------------------------------------------------
  assign window_ok = pin_q.feedback_ok_low & !pin_q.feedback_over;

  bfpg_pwrgood #(
    .DELAY_CYC(GOOD_DELAY_CYC),
    .BLANK_CYC(GOOD_BLANK_CYC)
  ) u_pwrgood
  (
    .clk_i(SYS_CLK_I),
    .rst_ni(rst_n),
    .force_low_i(!en_ok || fault || st_q == ST_LATCHED),
    .run_i(st_q == ST_RUN),
    .window_ok_i(window_ok),
    .good_o(good_int)
  );

  assign HS_ON_O = hs_q;
  assign LS_ON_O = ls_q;
  assign DISCHARGE_O = dis_q;
  assign RAMP_START_O = ramp_q;
  assign POWER_SAVE_O = psave_q;
  assign PWR_GOOD_O = 1'b0;
  assign PWR_GOOD_OE_O = !good_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_oc_cuts_high:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (switching && pin_q.overcurrent) |=> !hs_q ##0 (ls_q || st_q != ST_RUN && st_q != ST_SOFT))
    else $error("high side stayed on during overcurrent");

  a_no_midcycle_on:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (oc_term_q && !cycle_start) |=> !hs_q)
    else $error("high side restarted inside limited cycle");

  a_trip_to_pause:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (trip && !LATCH_OFF_VARIANT && en_ok && !fault) |=> st_q == ST_HICCUP ##1 !hs_q)
    else $error("32 limit cycles did not start the pause");

  a_pause_restart:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (st_q == ST_HICCUP && tmr_q == HICCUP_CYC - CNT_ONE && en_ok && !fault)
    |=> st_q == ST_SOFT && ramp_q)
    else $error("pause end did not restart through soft start");

  a_latch_holds:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (st_q == ST_LATCHED && en_ok) |=> st_q == ST_LATCHED && !hs_q && !ls_q)
    else $error("latched converter left latch with enable high");

  a_fault_idle:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    fault |=> !hs_q && !ls_q)
    else $error("power stage active under fault");

  a_disable_sink:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    !en_ok |=> dis_q && st_q == ST_OFF && !hs_q)
    else $error("disable did not stop and discharge");

  a_forced_pwm:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    pin_q.forced_pwm |=> !psave_q)
    else $error("power save entered in forced mode");

  a_occ_clear:
  assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
    (switching && cycle_start && !oc_term_q) |=> occ_q == 6'h00)
    else $error("limit counter not cleared after clean cycle");

endmodule

// ==== bfpg_pkg.sv ====
// Shared constants, types and register map of the converter supervisor
package bfpg_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  typedef logic [20:0] bfpg_cnt_t;
  localparam bfpg_cnt_t CNT_ZERO = 21'h0_0000;
  localparam bfpg_cnt_t CNT_ONE = 21'h0_0001;

  localparam int unsigned LOAD_MAX_US = 120;
  localparam int unsigned HICCUP_PAUSE_US = 9600;
  localparam int unsigned OVERVOLT_DEGLITCH_US = 35;
  localparam int unsigned PWR_GOOD_BLANK_US = 40;
  localparam int unsigned PWR_GOOD_DELAY_US = 125;

  // Longest time rounds down, least times round up
  localparam bfpg_cnt_t LOAD_CYCLES = bfpg_cnt_t'((LOAD_MAX_US * 1000) / CLK_PERIOD_NS);
  localparam bfpg_cnt_t HICCUP_CYCLES =
    bfpg_cnt_t'((HICCUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam bfpg_cnt_t OVERVOLT_CYCLES =
    bfpg_cnt_t'((OVERVOLT_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam bfpg_cnt_t PWR_GOOD_BLANK_CYCLES =
    bfpg_cnt_t'((PWR_GOOD_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam bfpg_cnt_t PWR_GOOD_DELAY_CYCLES =
    bfpg_cnt_t'((PWR_GOOD_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [5:0] OC_TRIP_COUNT = 6'h20;
  localparam logic [5:0] OC_COUNT_ONE = 6'h01;

  // ----------------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_LOAD    = 6'h02,
    ST_SOFT    = 6'h04,
    ST_RUN     = 6'h08,
    ST_HICCUP  = 6'h10,
    ST_LATCHED = 6'h20
  } bfpg_state_t;

  typedef struct packed {
    logic enable;
    logic undervolt;
    logic thermal;
    logic overcurrent;
    logic feedback_ok_low;
    logic feedback_over;
    logic near_vin;
    logic forced_pwm;
    logic zero_cross;
    logic pwm_on;
    logic ramp_done;
    logic cycle_clk;
  } bfpg_pins_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } bfpg_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } bfpg_axi_rsp_t;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_EVENT_OFS = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned EV_OC_CYCLE = 0;
  localparam int unsigned EV_HICCUP = 1;
  localparam int unsigned EV_OC_LATCH = 2;
  localparam int unsigned EV_OVERVOLT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== bfpg_axil_slave.sv ====
// AXI4-Lite slave front end with one-cycle register strobes
`timescale 1ns/1ps

module bfpg_axil_slave
(
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire bfpg_pkg::bfpg_axi_req_t axi_req_i,
  output bfpg_pkg::bfpg_axi_rsp_t axi_rsp_o,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  import bfpg_pkg::*;

  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic aw_fire, w_fire, ar_fire;

  always_comb
  begin
    aw_fire = axi_req_i.awvalid & !aw_have_q & !bvalid_q;
    w_fire = axi_req_i.wvalid & !w_have_q & !bvalid_q;
    ar_fire = axi_req_i.arvalid & !rvalid_q;
    aw_have_d = aw_have_q | aw_fire;
    w_have_d = w_have_q | w_fire;
    aw_addr_d = aw_fire ? axi_req_i.awaddr : aw_addr_q;
    w_data_d = w_fire ? axi_req_i.wdata : w_data_q;
    w_strb_d = w_fire ? axi_req_i.wstrb : w_strb_q;
    // Address and data may arrive in either order; write once both are held
    wr_en_o = aw_have_d & w_have_d;
    wr_addr_o = aw_addr_d;
    wr_data_o = w_data_d;
    wr_strb_o = w_strb_d;
    bvalid_d = bvalid_q & !axi_req_i.bready;
    bresp_d = bresp_q;
    if (wr_en_o)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end
    rd_en_o = ar_fire;
    rd_addr_o = axi_req_i.araddr;
    rvalid_d = rvalid_q & !axi_req_i.rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_data_i;
      rresp_d = rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign axi_rsp_o = '{awready: !aw_have_q & !bvalid_q, wready: !w_have_q & !bvalid_q,
                       bresp: bresp_q, bvalid: bvalid_q, arready: !rvalid_q,
                       rdata: rdata_q, rresp: rresp_q, rvalid: rvalid_q};

endmodule

// ==== bfpg_pwrgood.sv ====
// Power-good window qualification with start delay and edge blanking
`timescale 1ns/1ps

module bfpg_pwrgood #(
  parameter bfpg_pkg::bfpg_cnt_t DELAY_CYC = bfpg_pkg::PWR_GOOD_DELAY_CYCLES,
  parameter bfpg_pkg::bfpg_cnt_t BLANK_CYC = bfpg_pkg::PWR_GOOD_BLANK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic force_low_i,
  input wire logic run_i,
  input wire logic window_ok_i,
  output logic good_o
);
  import bfpg_pkg::*;

  logic good_q, good_d, first_q, first_d, target;
  bfpg_cnt_t dly_q, dly_d, blank_q, blank_d;

  always_comb
  begin
    first_d = first_q;
    dly_d = CNT_ZERO;
    if (!run_i || force_low_i)
      first_d = 1'b0;
    else if (!first_q)
    begin
      dly_d = dly_q + CNT_ONE;
      if (dly_q == DELAY_CYC - CNT_ONE)
        first_d = 1'b1;
    end
    target = run_i & first_q & window_ok_i;
    good_d = good_q;
    blank_d = CNT_ZERO;
    if (force_low_i)
      good_d = 1'b0;
    else if (target != good_q)
    begin
      blank_d = blank_q + CNT_ONE;
      if (blank_q == BLANK_CYC - CNT_ONE)
      begin
        good_d = target;
        blank_d = CNT_ZERO;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      good_q <= 1'b0;
      first_q <= 1'b0;
      dly_q <= CNT_ZERO;
      blank_q <= CNT_ZERO;
    end
    else
    begin
      good_q <= good_d;
      first_q <= first_d;
      dly_q <= dly_d;
      blank_q <= blank_d;
    end
  end

  assign good_o = good_q;

  a_good_forced_low:
  assert property (@(posedge clk_i) disable iff (!rst_ni) force_low_i |=> !good_q)
    else $error("power good not low while forced");

  a_good_blanked_rise:
  assert property (@(posedge clk_i) disable iff (!rst_ni)
    (!good_q && blank_q != BLANK_CYC - CNT_ONE) |=> !good_q)
    else $error("power good rose before blanking ended");

endmodule

// ==== bfpg_stage_model.sv ====
// Power stage model: oscillator, modulator, ramp, pulled-up good pin
`timescale 1ns/1ps

module bfpg_stage_model
(
  input wire logic clk_i,
  input wire logic ramp_start_i,
  input wire logic good_oe_i,
  output logic cycle_clk_o,
  output logic pwm_on_o,
  output logic ramp_done_o,
  output logic good_pin_o
);
  logic [2:0] ph_q = 3'h0;
  logic [5:0] ramp_q = 6'h00;
  initial cycle_clk_o = 1'b0;
  initial pwm_on_o = 1'b0;
  initial ramp_done_o = 1'b0;
  // Pull-up wins unless the supervisor sinks the pin
  assign good_pin_o = ~good_oe_i;
  always @(posedge clk_i)
  begin
    ph_q <= ph_q + 3'h1;
    cycle_clk_o <= ~ph_q[2];
    pwm_on_o <= (ph_q < 3'h2);
    ramp_q <= !ramp_start_i ? 6'h00 : (ramp_q == 6'h28) ? ramp_q : ramp_q + 6'h01;
    ramp_done_o <= (ramp_q == 6'h28);
  end
endmodule

// ==== tb.sv ====
// Self-checking bench of the supervisor, hiccup build
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module tb;
  import bfpg_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, uv = 0, hot = 0, oc = 0, fb_ok = 0;
  logic near = 0, fpwm = 0, zc = 0, fb_over = 0;
  logic hs, ls, dis, ramp, psave, good_oe, cyc, pwm, rdone, pin;
  bfpg_axi_req_t req = '0;
  bfpg_axi_rsp_t rsp;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares = 0, total_checks = 0, k;

  initial forever #4 clk = ~clk;

  bfpg_ctrl #(.LOAD_CYC(21'h0_0014), .HICCUP_CYC(21'h0_003c), .OVERVOLT_CYC(21'h0_000a),
    .GOOD_DELAY_CYC(21'h0_000c), .GOOD_BLANK_CYC(21'h0_0008)) dut (.SYS_CLK_I(clk),
    .ARST_N_I(rst_n), .S_AXI_REQ_I(req), .S_AXI_RSP_O(rsp), .ENABLE_I(en),
    .INPUT_UNDERVOLTAGE_I(uv), .THERMAL_TRIP_I(hot), .HS_OVERCURRENT_I(oc),
    .FEEDBACK_LOW_OK_I(fb_ok), .FEEDBACK_OVER_I(fb_over), .NEAR_VIN_I(near),
    .MODE_FORCED_PWM_I(fpwm), .ZERO_CROSS_I(zc), .PWM_ON_I(pwm), .RAMP_DONE_I(rdone),
    .CYCLE_CLK_I(cyc), .PWR_GOOD_I(pin), .HS_ON_O(hs), .LS_ON_O(ls), .DISCHARGE_O(dis),
    .RAMP_START_O(ramp), .POWER_SAVE_O(psave), .PWR_GOOD_O(), .PWR_GOOD_OE_O(good_oe));

  bfpg_stage_model stage (.clk_i(clk), .ramp_start_i(ramp), .good_oe_i(good_oe),
    .cycle_clk_o(cyc), .pwm_on_o(pwm), .ramp_done_o(rdone), .good_pin_o(pin));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask

  task automatic wait_state(input logic [5:0] s);
    int n;
    for (n = 0; n < 200; n++)
    begin
      rd(REG_STATUS_OFS);
      if (d[5:0] === s) break;
    end
    `CHK(d[5:0], s)
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({dis, good_oe, hs}, 3'b110)
    rd(REG_CTRL_OFS);
    `CHK(d, CTRL_RESET)
    rd(8'h40);
    `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
    fb_ok <= 1'b1;
    en <= 1'b1;
    wait_state(6'h02);
    wait_state(6'h04);
    `CHK(ramp, 1'b1)
    wait_state(6'h08);
    `CHK(good_oe, 1'b1)
    for (k = 0; k < 100 && good_oe; k++) @(posedge clk);
    `CHK({good_oe, pin, dis}, 3'b010)
    fb_over <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(good_oe, 1'b1)
    fb_over <= 1'b0;
    for (k = 0; k < 100 && good_oe; k++) @(posedge clk);
    `CHK(good_oe, 1'b0)
    fpwm <= 1'b1;
    zc <= 1'b1;
    repeat (16) @(posedge clk);
    `CHK(psave, 1'b0)
    fpwm <= 1'b0;
    zc <= 1'b0;
    near <= 1'b1;
    repeat (8) @(posedge clk);
    for (k = 0; k < 10; k++)
    begin
      @(posedge clk);
      `CHK({hs, ls}, 2'b10)
    end
    near <= 1'b0;
    oc <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({hs, ls}, 2'b01)
    wait_state(6'h10);
    `CHK({hs, ls}, 2'b00)
    oc <= 1'b0;
    wait_state(6'h04);
    wait_state(6'h08);
    for (k = 0; k < 2; k++)
    begin
      uv <= (k == 0);
      hot <= (k == 1);
      repeat (8) @(posedge clk);
      `CHK({hs, ls, good_oe}, 3'b001)
      uv <= 1'b0;
      hot <= 1'b0;
      wait_state(6'h08);
    end
    wr(REG_CTRL_OFS, 32'h0000_0000);
    wait_state(6'h01);
    wr(REG_CTRL_OFS, 32'h0000_0001);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({dis, hs, ls, good_oe}, 4'b1001)
    finish_test();
  end
endmodule
